/* hdl/uart_break_wakeup.sv */
// break transmit, break receive, wake-on-break and auto-baud of a serial transceiver
// assumes rx_pin is asynchronous; sleep and the register port are on clk
//
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "uart_break_regs.svh"

// Notes on behaviour
// - sleep stops baud ticks and normal reception
// - wake-on-break only in asynchronous mode
// - wake enabled: receiver held idle, watching line
// - wake event is falling edge on rx
// - wake event sets receive interrupt flag
// - reading receive data clears receive flag
// - rising edge ending break clears wake enable
// - nonzero char: first low stretch is wake
// - wake clear needs no baud ticks
// - break is start, twelve zeros, stop
// - data write with send-break starts break
// - send-break cleared after break stop bit
// - shift-empty flag tracks breaks like characters
// - transmit flag shows data register empty
// - received break: flag, framing error, zero data
// - after wake, next byte received normally
// - wake plus auto-baud measures following byte
module uart_break_wakeup (
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire uart_break_pkg::reg_req_t    bus_req,
  output logic [31:0]                      rdata,
  input  wire logic                        rx_pin,
  input  wire logic                        sleep,
  output logic                             tx_pin,
  output logic                             receive_int_flag,
  output logic                             transmit_buffer_empty_flag
);

  typedef struct packed {
    logic                      rx_meta;
    logic                      rx_sync;
    logic                      rx_prev;
    uart_break_pkg::tx_state_t tx_state;
    logic                      transmitter_on;
    logic                      send_break_request;
    logic                      brk;
    logic [7:0]                tx_buf;
    logic                      tx_empty;
    logic [8:0]                tx_shift;
    logic [3:0]                tx_bits;
    logic [3:0]                tx_os;
    logic                      tx_line;
    uart_break_pkg::rx_state_t rx_state;
    logic                      rx_en;
    logic                      sync_mode;
    logic                      wake_on_break_enable;
    logic                      wake_fall;
    logic                      autobaud_enable;
    uart_break_pkg::ab_state_t ab_state;
    logic [2:0]                ab_rises;
    logic [15:0]               ab_cnt;
    logic                      rx_int;
    logic                      framing_error_flag;
    logic [7:0]                rx_data;
    logic [7:0]                rx_shift;
    logic [3:0]                rx_bits;
    logic [3:0]                rx_os;
    logic [15:0]               div;
    logic [31:0]               rdata;
  } core_state_t;

  core_state_t st_reg;
  core_state_t st_next;
  logic        tick;
  logic        rx_fall;
  logic        rx_rise;

  function automatic logic hit(input uart_break_pkg::reg_req_t r, input logic [7:0] ofs);
    hit = r.addr == ofs;
  endfunction

  // ****************************************************************
  // oversampling tick, halted in sleep
  // ****************************************************************
  baud_tick #(.W(16)) u_tick (
    .clk     (clk),
    .rst_n   (rst_n),
    .enable  (!sleep),
    .divisor (st_reg.div),
    .tick    (tick)
  );

  // edges look only at the second synchroniser stage and its delayed copy
  assign rx_fall = st_reg.rx_prev & ~st_reg.rx_sync;
  assign rx_rise = ~st_reg.rx_prev & st_reg.rx_sync;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    st_next = st_reg;
    st_next.rx_meta = rx_pin;
    st_next.rx_sync = st_reg.rx_meta;
    st_next.rx_prev = st_reg.rx_sync;
    st_next.rdata = 32'h0000_0000;

    // register writes
    if (bus_req.wr) begin
      if (hit(bus_req, `OFS_TX_DATA) && st_reg.tx_empty) begin
        st_next.tx_buf = bus_req.wdata[7:0];
        st_next.tx_empty = 1'b0;
      end
      if (hit(bus_req, `OFS_TX_CTRL)) begin
        st_next.transmitter_on = bus_req.wdata[`TXC_ON];
        st_next.send_break_request = bus_req.wdata[`TXC_SEND_BREAK_REQUEST];
      end
      if (hit(bus_req, `OFS_RX_CTRL)) begin
        st_next.rx_en = bus_req.wdata[`RXC_EN];
        st_next.sync_mode = bus_req.wdata[`RXC_SYNC];
      end
      if (hit(bus_req, `OFS_BAUD_CTRL)) begin
        st_next.autobaud_enable = bus_req.wdata[`BC_AUTOBAUD_ENABLE];
        st_next.wake_on_break_enable = bus_req.wdata[`BC_WUE];
        st_next.ab_state = uart_break_pkg::AB_FALL;
      end
      if (hit(bus_req, `OFS_BAUD_DIV)) begin
        st_next.div = bus_req.wdata[15:0];
      end
    end

    // register reads; the flag clear comes first so that a set below wins
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        `OFS_RX_DATA: begin
          st_next.rdata[7:0] = st_reg.rx_data;
          st_next.rx_int = 1'b0;
        end
        `OFS_TX_CTRL: begin
          st_next.rdata[`TXC_ON] = st_reg.transmitter_on;
          st_next.rdata[`TXC_SEND_BREAK_REQUEST] = st_reg.send_break_request;
          st_next.rdata[`TXC_SHIFT_REG_EMPTY_FLAG] = st_reg.tx_state == uart_break_pkg::TX_IDLE;
          st_next.rdata[`TXC_TRANSMIT_BUFFER_EMPTY_FLAG] = st_reg.tx_empty;
        end
        `OFS_RX_CTRL: begin
          st_next.rdata[`RXC_EN] = st_reg.rx_en;
          st_next.rdata[`RXC_SYNC] = st_reg.sync_mode;
          st_next.rdata[`RXC_FRAMING_ERROR_FLAG] = st_reg.framing_error_flag;
          st_next.rdata[`RXC_RECEIVE_INT_FLAG] = st_reg.rx_int;
        end
        `OFS_BAUD_CTRL: begin
          st_next.rdata[`BC_AUTOBAUD_ENABLE] = st_reg.autobaud_enable;
          st_next.rdata[`BC_WUE] = st_reg.wake_on_break_enable;
          st_next.rdata[`BC_RECEIVE_IDLE_FLAG] = st_reg.rx_state == uart_break_pkg::RX_IDLE &&
                                     st_reg.ab_state == uart_break_pkg::AB_FALL;
        end
        `OFS_BAUD_DIV: st_next.rdata[15:0] = st_reg.div;
        default: st_next.rdata = 32'h0000_0000;
      endcase
    end

    // ****************************************************************
    // transmitter
    // ****************************************************************
    unique case (st_reg.tx_state)
      uart_break_pkg::TX_IDLE: begin
        st_next.tx_line = 1'b1;
        if (!st_reg.tx_empty && st_reg.transmitter_on && !sleep) begin
          // buffered byte is dropped when a break is pending
          st_next.brk = st_reg.send_break_request;
          st_next.tx_shift = st_reg.send_break_request ? 9'h000 : {st_reg.tx_buf, 1'b0};
          st_next.tx_bits = st_reg.send_break_request ? `BRK_BITS : `DATA_BITS;
          st_next.tx_os = 4'h0;
          st_next.tx_empty = 1'b1;
          st_next.tx_line = 1'b0;
          st_next.tx_state = uart_break_pkg::TX_BITS;
        end
      end
      uart_break_pkg::TX_BITS: begin
        if (tick) begin
          st_next.tx_os = st_reg.tx_os + 4'h1;
          if (st_reg.tx_os == `OS_LAST) begin
            st_next.tx_shift = {1'b0, st_reg.tx_shift[8:1]};
            st_next.tx_bits = st_reg.tx_bits - 4'h1;
            st_next.tx_line = st_reg.tx_shift[1];
            if (st_reg.tx_bits == 4'h1) begin
              st_next.tx_line = 1'b1;
              st_next.tx_state = uart_break_pkg::TX_STOP;
            end
          end
        end
      end
      uart_break_pkg::TX_STOP: begin
        if (tick) begin
          st_next.tx_os = st_reg.tx_os + 4'h1;
          if (st_reg.tx_os == `OS_LAST) begin
            // clearing here lets a preloaded sync byte follow as data
            if (st_reg.brk) begin
              st_next.send_break_request = 1'b0;
            end
            st_next.brk = 1'b0;
            st_next.tx_state = uart_break_pkg::TX_IDLE;
          end
        end
      end
      default: st_next.tx_state = uart_break_pkg::TX_IDLE;
    endcase

    // ****************************************************************
    // wake on break: runs on the line edges alone, no tick needed
    // ****************************************************************
    if (st_reg.wake_on_break_enable && !st_reg.sync_mode) begin
      if (rx_fall) begin
        st_next.rx_int = 1'b1;
        st_next.wake_fall = 1'b1;
      end else if (st_reg.wake_fall && rx_rise) begin
        st_next.wake_on_break_enable = 1'b0;
        st_next.wake_fall = 1'b0;
      end
    end else begin
      st_next.wake_fall = 1'b0;
    end

    // ****************************************************************
    // auto-baud: measures eight bit times of a sync byte
    // ****************************************************************
    if (st_reg.autobaud_enable && !st_reg.wake_on_break_enable && st_reg.rx_en &&
        !st_reg.sync_mode && !sleep) begin
      unique case (st_reg.ab_state)
        uart_break_pkg::AB_FALL: begin
          if (rx_fall) begin
            st_next.ab_state = uart_break_pkg::AB_RISE1;
          end
        end
        uart_break_pkg::AB_RISE1: begin
          if (rx_rise) begin
            st_next.ab_cnt = 16'h0001;
            st_next.ab_rises = 3'h1;
            st_next.ab_state = uart_break_pkg::AB_COUNT;
          end
        end
        uart_break_pkg::AB_COUNT: begin
          if (st_reg.ab_cnt != `AB_MAX) begin
            st_next.ab_cnt = st_reg.ab_cnt + 16'h0001;
          end
          if (rx_rise) begin
            st_next.ab_rises = st_reg.ab_rises + 3'h1;
            if (st_reg.ab_rises == `AB_RISES - 3'h1) begin
              st_next.div = (st_reg.ab_cnt >> `AB_SHIFT) - 16'h0001;
              st_next.autobaud_enable = 1'b0;
              st_next.rx_int = 1'b1;
              st_next.ab_state = uart_break_pkg::AB_FALL;
            end
          end
        end
        default: st_next.ab_state = uart_break_pkg::AB_FALL;
      endcase
    end

    // ****************************************************************
    // receiver; held idle while waking, measuring or asleep
    // ****************************************************************
    unique case (st_reg.rx_state)
      uart_break_pkg::RX_IDLE: begin
        if (rx_fall && st_reg.rx_en && !st_reg.sync_mode && !sleep &&
            !st_reg.wake_on_break_enable && !st_reg.autobaud_enable) begin
          st_next.rx_os = 4'h0;
          st_next.rx_state = uart_break_pkg::RX_START;
        end
      end
      uart_break_pkg::RX_START: begin
        if (tick) begin
          st_next.rx_os = st_reg.rx_os + 4'h1;
          if (st_reg.rx_os == `OS_MID) begin
            st_next.rx_os = 4'h0;
            st_next.rx_bits = 4'h0;
            st_next.rx_state = st_reg.rx_sync ? uart_break_pkg::RX_IDLE
                                              : uart_break_pkg::RX_DATA;
          end
        end
      end
      uart_break_pkg::RX_DATA: begin
        if (tick) begin
          st_next.rx_os = st_reg.rx_os + 4'h1;
          if (st_reg.rx_os == `OS_LAST) begin
            st_next.rx_shift = {st_reg.rx_sync, st_reg.rx_shift[7:1]};
            st_next.rx_bits = st_reg.rx_bits + 4'h1;
            if (st_reg.rx_bits == `RX_BITS - 4'h1) begin
              st_next.rx_state = uart_break_pkg::RX_STOP;
            end
          end
        end
      end
      uart_break_pkg::RX_STOP: begin
        if (tick) begin
          st_next.rx_os = st_reg.rx_os + 4'h1;
          if (st_reg.rx_os == `OS_LAST) begin
            // a break lands here as zero data with a low stop bit
            st_next.rx_data = st_reg.rx_shift;
            st_next.framing_error_flag = ~st_reg.rx_sync;
            st_next.rx_int = 1'b1;
            st_next.rx_state = uart_break_pkg::RX_IDLE;
          end
        end
      end
    endcase
    if (sleep) begin
      st_next.rx_state = uart_break_pkg::RX_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.rx_meta <= 1'b1;
      st_reg.rx_sync <= 1'b1;
      st_reg.rx_prev <= 1'b1;
      st_reg.tx_line <= 1'b1;
      st_reg.tx_empty <= 1'b1;
      st_reg.div <= `DIV_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rdata = st_reg.rdata;
  assign tx_pin = st_reg.tx_line;
  assign receive_int_flag = st_reg.rx_int;
  assign transmit_buffer_empty_flag = st_reg.tx_empty;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_WAKE_SETS_FLAG: assert property (
    st_reg.wake_on_break_enable && !st_reg.sync_mode && rx_fall |=> receive_int_flag)
    else $error("wake edge did not raise receive flag");
  AST_WAKE_RX_HELD: assert property (
    st_reg.wake_on_break_enable |=> st_reg.rx_state == uart_break_pkg::RX_IDLE ||
                                   $past(st_reg.rx_state) != uart_break_pkg::RX_IDLE)
    else $error("reception started while wake enabled");
  AST_WAKE_CLEARS: assert property (
    st_reg.wake_on_break_enable && st_reg.wake_fall && !st_reg.sync_mode && rx_rise
    && !bus_req.wr |=> !st_reg.wake_on_break_enable)
    else $error("wake enable not cleared by rising edge");
  AST_SYNC_NO_WAKE: assert property (
    st_reg.sync_mode |=> !st_reg.wake_fall)
    else $error("wake armed in synchronous mode");
  AST_READ_CLEARS: assert property (
    bus_req.rd && bus_req.addr == `OFS_RX_DATA && !st_reg.wake_on_break_enable &&
    !st_reg.autobaud_enable && st_reg.rx_state == uart_break_pkg::RX_IDLE
    |=> !receive_int_flag)
    else $error("receive data read left flag set");
  AST_BREAK_LOW: assert property (
    st_reg.brk && st_reg.tx_state == uart_break_pkg::TX_BITS |-> !tx_pin)
    else $error("break bit not low");
  AST_SEND_BREAK_REQUEST_AFTER_STOP: assert property (
    $fell(st_reg.send_break_request) && !$past(bus_req.wr) |->
    $past(st_reg.tx_state) == uart_break_pkg::TX_STOP && $past(st_reg.brk))
    else $error("send-break cleared outside break stop bit");
  AST_SHIFT_REG_EMPTY_FLAG_READ: assert property (
    bus_req.rd && bus_req.addr == `OFS_TX_CTRL |=>
    rdata[`TXC_SHIFT_REG_EMPTY_FLAG] == ($past(st_reg.tx_state) == uart_break_pkg::TX_IDLE))
    else $error("shift-empty status wrong");
  AST_TRANSMIT_BUFFER_EMPTY_FLAG_LOAD: assert property (
    !transmit_buffer_empty_flag && st_reg.tx_state == uart_break_pkg::TX_IDLE &&
    st_reg.transmitter_on && !sleep |=> transmit_buffer_empty_flag)
    else $error("buffer not handed to shift register");
  AST_RX_BREAK: assert property (
    st_reg.rx_state == uart_break_pkg::RX_STOP && tick && st_reg.rx_os == `OS_LAST &&
    st_reg.rx_shift == 8'h00 && !st_reg.rx_sync && !sleep
    |=> receive_int_flag && st_reg.framing_error_flag && st_reg.rx_data == 8'h00)
    else $error("received break not reported");

  COV_WAKE: cover property ($fell(st_reg.wake_on_break_enable) && !$past(bus_req.wr));
  COV_BREAK_SENT: cover property ($fell(st_reg.brk));
  COV_AUTOBAUD: cover property ($fell(st_reg.autobaud_enable) && !$past(bus_req.wr));
  COV_FRAMING: cover property ($rose(st_reg.framing_error_flag));

endmodule

`default_nettype wire

/* hdl/uart_break_regs.svh */
// register map, field positions, reset values and bit counts of the break/wake block
// assumes a 32-bit word register port with byte addresses
`ifndef UART_BREAK_REGS_SVH
`define UART_BREAK_REGS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define OFS_TX_DATA   8'h00
`define OFS_RX_DATA   8'h04
`define OFS_TX_CTRL   8'h08
`define OFS_RX_CTRL   8'h0c
`define OFS_BAUD_CTRL 8'h10
`define OFS_BAUD_DIV  8'h14

// ****************************************************************
// field positions
// ****************************************************************
`define TXC_ON     0
`define TXC_SEND_BREAK_REQUEST  1
`define TXC_SHIFT_REG_EMPTY_FLAG   2
`define TXC_TRANSMIT_BUFFER_EMPTY_FLAG   3
`define RXC_EN     0
`define RXC_SYNC   1
`define RXC_FRAMING_ERROR_FLAG   2
`define RXC_RECEIVE_INT_FLAG   3
`define BC_AUTOBAUD_ENABLE   0
`define BC_WUE     1
`define BC_RECEIVE_IDLE_FLAG   6

// ****************************************************************
// reset values and counts
// ****************************************************************
`define DIV_RESET   16'h0043
`define OS_LAST     4'hf
`define OS_MID      4'h7
`define DATA_BITS   4'h9
`define BRK_BITS    4'hd
`define RX_BITS     4'h8
`define AB_RISES    3'h5
`define AB_SHIFT    7
`define AB_MAX      16'hffff

`endif

/* hdl/uart_break_pkg.sv */
// types shared by the break/wake transceiver and its tick divider
// assumes nothing beyond the register header
package uart_break_pkg;

  typedef enum logic [1:0] {TX_IDLE, TX_BITS, TX_STOP} tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
  typedef enum logic [1:0] {AB_FALL, AB_RISE1, AB_COUNT} ab_state_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } tick_state_t;

endpackage

/* hdl/baud_tick.sv */
// sixteen-times oversampling tick divider
// assumes divisor is steady between writes; enable low stops ticks
`timescale 1ns/100ps
`default_nettype none

module baud_tick #(
  parameter int W = 16
) (
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire logic                        enable,
  input  wire logic [W-1:0]                divisor,
  output logic                             tick
);

  uart_break_pkg::tick_state_t st_reg;
  uart_break_pkg::tick_state_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (!enable) begin
      st_next.cnt = '0;
    end else if (st_reg.cnt >= 16'(divisor)) begin
      st_next.cnt = '0;
      st_next.tick = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick = st_reg.tick;

  AST_NO_TICK_ASLEEP: assert property (@(posedge clk) disable iff (!rst_n)
    !enable |=> !tick) else $error("tick while halted");

endmodule

`default_nettype wire

/* testbench/remote_node.sv */
// remote serial node that drives the receive line and watches the transmit line
// assumes it shares the bench clock; the line sits high when idle, as if pulled up
`timescale 1ns/100ps
`default_nettype none

module remote_node (
  input  wire logic clk,
  input  wire logic tx_pin,
  output logic      rx_pin
);
  int bit_clks = 16;

  initial rx_pin = 1'b1;

  // one level for n clocks, changed just after an edge
  task automatic drive(input logic v, input int n);
    @(posedge clk);
    rx_pin <= v;
    repeat (n - 1) @(posedge clk);
  endtask

  // a zero stop bit makes a framing fault on purpose
  task automatic send_char(input logic [7:0] d, input logic stop);
    drive(1'b0, bit_clks);
    for (int i = 0; i < 8; i++) drive(d[i], bit_clks);
    drive(stop, bit_clks);
    drive(1'b1, bit_clks);
  endtask

  task automatic low_run(output int n);
    n = 0;
    for (int w = 0; w < 2000 && tx_pin !== 1'b0; w++) @(posedge clk);
    while (tx_pin === 1'b0 && n < 4000) begin
      @(posedge clk);
      n++;
    end
  endtask

  // samples mid-bit, lsb first
  task automatic get_char(output logic [7:0] d);
    for (int w = 0; w < 2000 && tx_pin !== 1'b0; w++) @(posedge clk);
    repeat (bit_clks / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (bit_clks) @(posedge clk);
      d[i] = tx_pin;
    end
  endtask
endmodule

`default_nettype wire

/* testbench/uart_break_wakeup_tb_top.sv */
// self-checking bench: break send and receive, wake-on-break, auto-baud
// assumes the register map of the block header and the remote_node partner
`timescale 1ns/100ps
`default_nettype none
`include "uart_break_regs.svh"

`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
  $display("BAD %0t got %h want %h", $time, (g), (e)); end end

module uart_break_wakeup_tb_top;
  logic                     clk;
  logic                     rst_n;
  uart_break_pkg::reg_req_t bus_req;
  logic [31:0]              rdata;
  logic                     sleep;
  logic                     tx_pin;
  logic                     rx_line;
  logic                     receive_int_flag;
  logic                     transmit_buffer_empty_flag;
  logic [31:0]              d;
  int                       fail_count = 0;
  int                       n_compared = 0;

  uart_break_wakeup DUT (.clk(clk), .rst_n(rst_n), .bus_req(bus_req), .rdata(rdata),
    .rx_pin(rx_line), .sleep(sleep), .tx_pin(tx_pin), .receive_int_flag(receive_int_flag),
    .transmit_buffer_empty_flag(transmit_buffer_empty_flag));
  remote_node node (.clk(clk), .tx_pin(tx_pin), .rx_pin(rx_line));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ****************************************************************
  // bus and helper tasks
  // ****************************************************************
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req.wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic wait_flag(input int n);
    for (int i = 0; i < n && receive_int_flag !== 1'b1; i++) @(posedge clk);
  endtask

  task automatic finish_test;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset;
    `CHK(tx_pin, 1'b1)
    `CHK(transmit_buffer_empty_flag, 1'b1)
    bus_rd(`OFS_BAUD_DIV, d);
    `CHK(d, 32'h0000_0043)
    bus_rd(8'h3c, d);
    `CHK(d, 32'h0)
    bus_wr(`OFS_BAUD_DIV, 32'h0); // one tick a clock: a bit is 16 clocks
    bus_wr(`OFS_RX_CTRL, 32'h1);
  endtask

  task automatic t_header;
    int          lc;
    logic [7:0]  sy;
    logic [31:0] c1;
    logic [31:0] c2;
    bus_wr(`OFS_TX_CTRL, 32'h3);
    bus_wr(`OFS_TX_DATA, 32'ha5);
    bus_wr(`OFS_TX_DATA, 32'h55);
    fork
      begin
        node.low_run(lc);
        node.get_char(sy);
      end
      begin
        bus_rd(`OFS_TX_CTRL, c1);
        `CHK(transmit_buffer_empty_flag, 1'b0)
        repeat (260) @(posedge clk);
        bus_rd(`OFS_TX_CTRL, c2);
      end
    join
    `CHK((lc + 8) / 16, 13)
    `CHK(sy, 8'h55)
    `CHK(c1[`TXC_SHIFT_REG_EMPTY_FLAG], 1'b0)
    `CHK(c2[`TXC_SEND_BREAK_REQUEST], 1'b0)
    repeat (40) @(posedge clk);
    bus_rd(`OFS_TX_CTRL, d);
    `CHK(d[`TXC_SHIFT_REG_EMPTY_FLAG], 1'b1)
    `CHK(transmit_buffer_empty_flag, 1'b1)
  endtask

  task automatic t_break_rx;
    node.send_char(8'h00, 1'b0);
    wait_flag(200);
    `CHK(receive_int_flag, 1'b1)
    bus_rd(`OFS_RX_CTRL, d);
    `CHK(d[`RXC_FRAMING_ERROR_FLAG], 1'b1)
    bus_rd(`OFS_RX_DATA, d);
    `CHK(d[7:0], 8'h00)
    `CHK(receive_int_flag, 1'b0)
  endtask

  // sleep blocks normal reception; synchronous mode blocks wake
  task automatic t_refused;
    @(posedge clk);
    sleep <= 1'b1;
    node.send_char(8'h3c, 1'b1);
    `CHK(receive_int_flag, 1'b0)
    sleep <= 1'b0;
    bus_wr(`OFS_RX_CTRL, 32'h3);
    bus_wr(`OFS_BAUD_CTRL, 32'h2);
    node.drive(1'b0, 40);
    node.drive(1'b1, 20);
    `CHK(receive_int_flag, 1'b0)
    bus_wr(`OFS_BAUD_CTRL, 32'h0);
    bus_wr(`OFS_RX_CTRL, 32'h1);
  endtask

  task automatic t_wake;
    bus_rd(`OFS_BAUD_CTRL, d);
    `CHK(d[`BC_RECEIVE_IDLE_FLAG], 1'b1)
    bus_wr(`OFS_BAUD_CTRL, 32'h2);
    sleep <= 1'b1;
    node.drive(1'b0, 8);
    `CHK(receive_int_flag, 1'b1)
    node.drive(1'b0, 200);
    bus_rd(`OFS_BAUD_CTRL, d);
    `CHK(d[`BC_WUE], 1'b1)
    node.drive(1'b1, 8);
    bus_rd(`OFS_BAUD_CTRL, d);
    `CHK(d[`BC_WUE], 1'b0)
    bus_rd(`OFS_RX_DATA, d);
    `CHK(receive_int_flag, 1'b0)
    @(posedge clk);
    sleep <= 1'b0;
    fork
      node.send_char(8'ha3, 1'b1);
      begin
        repeat (40) @(posedge clk);
        bus_rd(`OFS_BAUD_CTRL, d);
      end
    join
    `CHK(d[`BC_RECEIVE_IDLE_FLAG], 1'b0)
    `CHK(receive_int_flag, 1'b1)
    bus_rd(`OFS_RX_DATA, d);
    `CHK(d[7:0], 8'ha3)
  endtask

  // sender runs at 32 clocks a bit, which measures as a divisor of one
  task automatic t_autobaud;
    bus_wr(`OFS_BAUD_CTRL, 32'h3);
    node.bit_clks = 32;
    node.drive(1'b0, 13 * 32);
    node.drive(1'b1, 32);
    bus_rd(`OFS_RX_DATA, d);
    node.send_char(8'h55, 1'b1);
    node.bit_clks = 16;
    wait_flag(100);
    `CHK(receive_int_flag, 1'b1)
    bus_rd(`OFS_BAUD_DIV, d);
    `CHK(d, 32'h0000_0001)
    bus_rd(`OFS_BAUD_CTRL, d);
    `CHK(d[1:0], 2'b00)
    bus_rd(`OFS_RX_DATA, d);
  endtask

  initial begin
    rst_n = 1'b0;
    sleep = 1'b0;
    bus_req = '0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_header();
    t_break_rx();
    t_refused();
    t_wake();
    t_autobaud();
    finish_test();
  end

  // the whole run needs some 2000 clocks
  initial begin
    repeat (50000) @(posedge clk);
    fail_count++;
    finish_test();
  end
endmodule

`default_nettype wire
